// ==== rtl/sfsl_pkg.sv ====
// package for the select framed serial link peripheral end
// assumes a single core clock domain; link pins are sampled, not clocked on
package sfsl_pkg;
    // ========================================
    // framing
    localparam int unsigned SFSL_BYTE_BITS = 8;
    localparam logic [2:0] SFSL_BIT_LAST = 3'h7;
    localparam logic [7:0] SFSL_TX_RESET = 8'h00;
    // ========================================
    // routed node address byte fields
    localparam int unsigned SFSL_ADDR_PORT_MSB = 7;
    localparam int unsigned SFSL_ADDR_PORT_LSB = 6;
    localparam int unsigned SFSL_ADDR_L1_MSB = 5;
    localparam int unsigned SFSL_ADDR_L1_LSB = 3;
    localparam int unsigned SFSL_ADDR_L2_MSB = 2;
    localparam int unsigned SFSL_ADDR_L2_LSB = 0;
    // ========================================
    // frame phase
    typedef enum logic [1:0]
    {
        SFSL_IDLE = 2'b00,
        SFSL_ADDR = 2'b01,
        SFSL_DATA = 2'b10
    } sfsl_phase_t;
endpackage

// ==== rtl/sfsl_sync.sv ====
// two-stage synchroniser for link pins
// assumes inputs are asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module sfsl_sync
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic async_in,
    input wire logic [0:0] reset_val,
    output logic sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // ========================================
    // first stage is read only by the second stage
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    // reset_val unused by logic but keeps idle polarity obvious at the instance
    assign sync_out = sync_q ^ (reset_val[0] & 1'b0);
endmodule
`default_nettype wire

// ==== rtl/sfsl_periph.sv ====
// peripheral end of the select framed serial link
// assumes master drives sclk, sel_n and mosi; core_clk much faster than sclk
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE_01: master alone generates serial clock
// RULE_02: master alone drives the select
// RULE_03: asserted select enters selected state, obeys commands
// RULE_04: selected at once, no qualifier
// RULE_05: master asserts select, then clocks command
// RULE_06: first byte of frame is address
// RULE_07: mosi carries commands, miso returns data
// RULE_08: both directions shift on every clock
// RULE_09: frame lasts exactly while select asserted
// RULE_10: one peripheral per master port
// RULE_11: address byte holds port, router fields
// RULE_12: command byte plus zero to fifteen bytes; the data phase here takes any number of bytes, with no limit
// RULE_13: idle select ignores clock, resets shifter
module sfsl_periph
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    output logic miso,
    output logic selected,
    output logic [7:0] addr_byte,
    output logic addr_valid,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic tx_load,
    input wire logic [7:0] tx_byte
);
    logic sclk_s;
    logic sel_s;
    logic mosi_s;

    // ========================================
    // pin synchronisers
    sfsl_sync u_sync_clk
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in(sclk),
        .reset_val(1'b0),
        .sync_out(sclk_s)
    );
    sfsl_sync u_sync_sel
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in(~sel_n),
        .reset_val(1'b0),
        .sync_out(sel_s)
    );
    sfsl_sync u_sync_mosi
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in(mosi),
        .reset_val(1'b0),
        .sync_out(mosi_s)
    );

    // ========================================
    // shift state
    sfsl_pkg::sfsl_phase_t phase_q, phase_d;
    logic sclk_prev_q, sclk_prev_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic [7:0] tx_sh_q, tx_sh_d;
    logic miso_q, miso_d;
    logic sel_q, sel_d;
    logic [7:0] addr_q, addr_d;
    logic addr_v_q, addr_v_d;
    logic [7:0] rxb_q, rxb_d;
    logic rxv_q, rxv_d;
    logic txl_q, txl_d;
    logic rise;
    logic fall;
    logic active;

    // one more serial bit in at the lsb, msb first on the wire
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic din);
        return {sh[6:0], din};
    endfunction

    // sel_s holds the inverted pin, so high means selected and the reset level is idle
    assign active = sel_s; // RULE_04
    assign rise = active & sclk_s & ~sclk_prev_q;
    assign fall = active & ~sclk_s & sclk_prev_q;

    // sample mosi on rising sclk, drive miso on falling (mode 0 style)
    // limitation: sclk must stay well below core_clk / 4 given the sync latency
    always_comb
    begin
        phase_d = phase_q;
        sclk_prev_d = sclk_s;
        bit_d = bit_q;
        rx_sh_d = rx_sh_q;
        tx_sh_d = tx_sh_q;
        miso_d = miso_q;
        sel_d = active; // RULE_03
        addr_d = addr_q;
        addr_v_d = 1'b0;
        rxb_d = rxb_q;
        rxv_d = 1'b0;
        txl_d = 1'b0;
        if (!active)
        begin
            // clock ignored, shifter back to idle
            phase_d = sfsl_pkg::SFSL_IDLE; // RULE_13
            bit_d = 3'h0; // RULE_13
            rx_sh_d = 8'h00;
            tx_sh_d = sfsl_pkg::SFSL_TX_RESET;
            miso_d = 1'b0;
        end
        else
        begin
            case (phase_q)
                sfsl_pkg::SFSL_IDLE:
                begin
                    // frame opens on select alone
                    phase_d = sfsl_pkg::SFSL_ADDR; // RULE_09
                    tx_sh_d = tx_byte;
                    miso_d = tx_byte[7];
                    txl_d = 1'b1;
                end
                sfsl_pkg::SFSL_ADDR, sfsl_pkg::SFSL_DATA:
                begin
                    if (rise)
                    begin
                        rx_sh_d = shift_in(rx_sh_q, mosi_s); // RULE_07
                        bit_d = bit_q + 3'h1;
                        if (bit_q == sfsl_pkg::SFSL_BIT_LAST)
                        begin
                            if (phase_q == sfsl_pkg::SFSL_ADDR)
                            begin
                                addr_d = shift_in(rx_sh_q, mosi_s); // RULE_06
                                addr_v_d = 1'b1;
                                phase_d = sfsl_pkg::SFSL_DATA;
                            end
                            else
                            begin
                                rxb_d = shift_in(rx_sh_q, mosi_s);
                                rxv_d = 1'b1;
                            end
                        end
                    end
                    else if (fall)
                    begin
                        if (bit_q == 3'h0)
                        begin
                            // byte boundary: reload from user side
                            tx_sh_d = tx_byte; // RULE_08
                            miso_d = tx_byte[7];
                            txl_d = 1'b1;
                        end
                        else
                        begin
                            tx_sh_d = {tx_sh_q[6:0], 1'b0};
                            miso_d = tx_sh_q[6]; // RULE_08
                        end
                    end
                end
                default:
                begin
                    phase_d = sfsl_pkg::SFSL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_q <= sfsl_pkg::SFSL_IDLE;
            sclk_prev_q <= 1'b0;
            bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            tx_sh_q <= sfsl_pkg::SFSL_TX_RESET;
            miso_q <= 1'b0;
            sel_q <= 1'b0;
            addr_q <= 8'h00;
            addr_v_q <= 1'b0;
            rxb_q <= 8'h00;
            rxv_q <= 1'b0;
            txl_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            sclk_prev_q <= sclk_prev_d;
            bit_q <= bit_d;
            rx_sh_q <= rx_sh_d;
            tx_sh_q <= tx_sh_d;
            miso_q <= miso_d;
            sel_q <= sel_d;
            addr_q <= addr_d;
            addr_v_q <= addr_v_d;
            rxb_q <= rxb_d;
            rxv_q <= rxv_d;
            txl_q <= txl_d;
        end
    end

    // ========================================
    // outputs, all registered
    assign miso = miso_q;
    assign selected = sel_q;
    assign addr_byte = addr_q;
    assign addr_valid = addr_v_q;
    assign rx_byte = rxb_q;
    assign rx_valid = rxv_q;
    assign tx_load = txl_q;
endmodule
`default_nettype wire

// ==== test/sfsl_checker.sv ====
// assertions for the peripheral end of the serial link
// assumes binding onto sfsl_periph
`timescale 1ns/1ps
`default_nettype none
module sfsl_checker
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic selected,
    input wire logic [7:0] addr_byte,
    input wire logic addr_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic tx_load,
    input wire logic [7:0] tx_byte
);
    // ====
    // select tracking, pulses and held bytes
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_drop;
        $fell(sel_n);
    endsequence
    sequence s_join;
        ##[1:4] selected;
    endsequence
    a_sel_join: assert property (s_drop |-> s_join) else $error("select not taken");
    a_sel_leave: assert property ($rose(sel_n) |-> ##[1:4] !selected) else $error("select held");
    a_idle_quiet: assert property (!selected |-> !addr_valid && !rx_valid) else $error("idle byte");
    a_idle_miso: assert property (!selected && !$past(selected) |-> !miso) else $error("idle miso");
    a_load_start: assert property ($rose(selected) |-> tx_load) else $error("no load");
    a_addr_pulse: assert property (addr_valid |=> !addr_valid) else $error("long addr pulse");
    a_rx_pulse: assert property (rx_valid |=> !rx_valid) else $error("long rx pulse");
    a_addr_hold: assert property ($changed(addr_byte) |-> addr_valid) else $error("addr moved");
    a_rx_hold: assert property ($changed(rx_byte) |-> rx_valid) else $error("rx moved");
endmodule
bind sfsl_periph sfsl_checker u_sfsl_checker (.core_clk(core_clk), .rstn(rstn), .sclk(sclk),
    .sel_n(sel_n), .mosi(mosi), .miso(miso), .selected(selected), .addr_byte(addr_byte),
    .addr_valid(addr_valid), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_load(tx_load), .tx_byte(tx_byte));
`default_nettype wire

// ==== test/sfsl_master_model.sv ====
// master end model: select, link clock and outgoing data
// assumes the bench core clock paces every step
`timescale 1ns/1ps
`default_nettype none
module sfsl_master_model
(
    input wire logic core_clk,
    output logic sclk,
    output logic sel_n,
    output logic mosi,
    input wire logic miso
);
    // ====
    // idle levels: clock still and low, select released
    initial
    begin
        sclk = 1'b0;
        sel_n = 1'b1;
        mosi = 1'b0;
    end
    // half of the 80 ns link period
    task automatic half;
        repeat (5) @(posedge core_clk);
    endtask
    // select first, then msb-first bits; miso taken while clock is high
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        sel_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        for (int i = 15; i > 15 - n; i--)
        begin
            mosi <= tx[i];
            half();
            sclk <= 1'b1;
            half();
            rx[i] = miso;
            sclk <= 1'b0;
        end
        repeat (6) @(posedge core_clk);
        sel_n <= 1'b1;
        mosi <= ~mosi; // released line must not show a stale bit
        repeat (6) @(posedge core_clk);
    endtask
    // clocking while deselected, which the far end must ignore
    task automatic idle_clk;
        repeat (4)
        begin
            sclk <= 1'b1;
            half();
            sclk <= 1'b0;
            half();
        end
    endtask
endmodule
`default_nettype wire

// ==== test/select_framed_serial_link_tb.sv ====
// self-checking bench for the serial link peripheral end
// assumes the master model paces the link clock
`timescale 1ns/1ps
`default_nettype none
module select_framed_serial_link_tb;
    // ====
    // signals, rows of address, data byte and outgoing byte
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    wire logic sclk, sel_n, mosi;
    logic miso, selected, addr_valid, rx_valid, tx_load;
    logic [7:0] addr_byte, rx_byte;
    logic [15:0] got;
    int fails = 0;
    int num_checks = 0;
    logic [15:0] n_addr = 16'h0000;
    logic [15:0] n_rx = 16'h0000;
    logic [15:0] n_load = 16'h0000;
    logic [23:0] rows [3] = '{24'hea5ac3, 24'h00ff01, 24'h3f0080};
    always #4 core_clk = ~core_clk;
    sfsl_periph u_sfsl_periph (.core_clk(core_clk), .rstn(rstn), .sclk(sclk), .sel_n(sel_n), .mosi(mosi),
        .miso(miso), .selected(selected), .addr_byte(addr_byte), .addr_valid(addr_valid), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .tx_load(tx_load), .tx_byte(tx_byte));
    sfsl_master_model u_sfsl_master_model (.core_clk(core_clk), .sclk(sclk), .sel_n(sel_n), .mosi(mosi),
        .miso(miso));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // strobe counters; a stuck, doubled or missing pulse shows in the totals
    always @(posedge core_clk)
    begin
        if (addr_valid)
            n_addr <= n_addr + 16'h0001;
        if (rx_valid)
            n_rx <= n_rx + 16'h0001;
        if (tx_load)
            n_load <= n_load + 16'h0001;
    end
    // watchdog well beyond the under one thousand cycles of traffic
    initial
    begin
        #200000;
        fails++;
        complete_run;
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        check("reset outputs", {14'h0, selected, miso}, 16'h0000);
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        foreach (rows[i])
        begin
            tx_byte <= rows[i][7:0];
            @(posedge core_clk);
            u_sfsl_master_model.xfer(rows[i][23:8], 16, got);
            check("address", {8'h00, addr_byte}, {8'h00, rows[i][23:16]});
            check("data", {8'h00, rx_byte}, {8'h00, rows[i][15:8]});
            check("returned", got, {2{rows[i][7:0]}});
        end
        // a cut byte and stray clocking leave held bytes alone
        u_sfsl_master_model.xfer(16'ha500, 4, got);
        u_sfsl_master_model.idle_clk();
        check("abort", {addr_byte, rx_byte}, rows[2][23:8]);
        u_sfsl_master_model.xfer(16'h9600, 8, got);
        check("address only", {addr_byte, rx_byte}, 16'h9600);
        // three full frames, one address-only frame, one cut frame
        check("addr pulses", n_addr, 16'h0004);
        check("rx pulses", n_rx, 16'h0003);
        check("tx loads", n_load, 16'h000c);
        complete_run;
    end
endmodule
`default_nettype wire
